// file: src/ddr_cmd_params.svh
// timing counts, field positions and reset values for the command and power-state block
`ifndef DDR_CMD_PARAMS_SVH
`define DDR_CMD_PARAMS_SVH
`define CLK_PERIOD_PS 5000
`define BANK_W 3
`define ADDR_W 14
`define COL_W 10
`define AUTO_PRE_BIT 10
`define NUM_BANKS 8
`define BYTE_LANES 2
`define BURST_LEN 4
`define AL_W 3
`define AL_RESET 3'h0
`define MR_A2_BIT 2
`define MR_A6_BIT 6
`define EMR1_SEL 3'h1
`define ROW_RESET 14'h0000
`endif

// file: src/ddr_cmd_pkg.sv
// types shared by the command and power-state block
package ddr_cmd_pkg;
  typedef enum logic [8:0] {
    CMD_DESEL = 9'h001,
    CMD_NOP = 9'h002,
    CMD_MRS = 9'h004,
    CMD_REF = 9'h008,
    CMD_PRE = 9'h010,
    CMD_ACT = 9'h020,
    CMD_WR = 9'h040,
    CMD_RD = 9'h080,
    CMD_BAD = 9'h100
  } cmd_t;

  typedef enum logic [4:0] {
    PS_IDLE = 5'h01,
    PS_ACTIVE = 5'h02,
    PS_PRE_PD = 5'h04,
    PS_ACT_PD = 5'h08,
    PS_SELF_REF = 5'h10
  } power_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [13:0] addr;
  } cmd_bus_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic auto_pre;
    logic [2:0] bank;
    logic [9:0] col;
  } col_req_t;
endpackage

// file: src/ddr_col_delay.sv
// additive-latency delay line for column commands
`include "ddr_cmd_params.svh"
module ddr_col_delay #(
  parameter int DEPTH = 7
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // control
  input wire logic [`AL_W-1:0] i_latency,
  input wire ddr_cmd_pkg::col_req_t i_req,
  // delayed request
  output ddr_cmd_pkg::col_req_t o_req
);
  import ddr_cmd_pkg::*;

  col_req_t stage [DEPTH];
  col_req_t next_stage [DEPTH];

  always_comb begin
    next_stage[0] = i_req;
    for (int i = 1; i < DEPTH; i++) begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= next_stage[i];
      end
    end
  end

  // zero latency passes straight through
  always_comb begin
    if (i_latency == 3'h0) begin
      o_req = i_req;
    end else if (int'(i_latency) <= DEPTH) begin
      o_req = stage[i_latency-3'h1];
    end else begin
      o_req = stage[DEPTH-1];
    end
  end
endmodule

// file: src/ddr_byte_mem.sv
// small byte-masked storage array with registered read data
module ddr_byte_mem #(
  parameter int AW = 6,
  parameter int LANES = 2
) (
  // clock
  input wire logic I_CLK,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [LANES*8-1:0] i_wdata,
  input wire logic [LANES-1:0] i_mask,
  // read port
  input wire logic [AW-1:0] i_raddr,
  output logic [LANES*8-1:0] o_rdata
);
  // one array per lane so that each lane's store has a single writing process
  // memory contents need no reset; only the read register matters
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [7:0] lane_mem [2**AW];
    logic [7:0] lane_rdata;
    always_ff @(posedge I_CLK) begin
      if (i_we && !i_mask[g]) begin
        lane_mem[i_waddr] <= i_wdata[g*8 +: 8];
      end
      lane_rdata <= lane_mem[i_raddr];
    end
    assign o_rdata[g*8 +: 8] = lane_rdata;
  end
endmodule

// file: src/ddr_cmd_power.sv
// command decode, bank tracking and power-state logic of the memory device
//
// Contract
// - clock-enable edges drive power-down and self-refresh
// - no refresh performed in power-down
// - masked bytes skip the write store
// - chip select high accepts no command
// - nop registers nothing, running operations continue
// - mode load targets register from bank inputs
// - activate opens row until precharged
// - read bursts from column, optional auto-precharge
// - write bursts from column, optional auto-precharge
// - column commands delayed by additive latency
// - precharge closes one or all banks
// - precharge to idle or precharging bank accepted
// - other bank accessible during auto-precharge
// - refresh uses internal row address
// - self-refresh keeps data, loop off, on at exit
// - termination follows input except in self-refresh
// - command decoded from strobes at rising edge
// - self-refresh exit seen without running clock
`include "ddr_cmd_params.svh"
module ddr_cmd_power #(
  parameter int NBANK = `NUM_BANKS,
  parameter int LANES = `BYTE_LANES,
  parameter int MEM_AW = 6
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // command pins
  input wire logic I_CKE,
  input wire ddr_cmd_pkg::cmd_bus_t I_CMD,
  input wire logic I_TERM_CTRL,
  // write data pins
  input wire logic [LANES*8-1:0] I_WDATA,
  input wire logic [LANES-1:0] I_BYTE_WRITE_MASK,
  // configuration
  input wire logic [`AL_W-1:0] I_ADDITIVE_LATENCY,
  // status
  output ddr_cmd_pkg::power_state_t O_POWER_STATE,
  output logic [NBANK-1:0] O_BANK_OPEN,
  output logic O_DLL_ON,
  output logic O_TERM_ON,
  output logic O_REFRESH_PULSE,
  output logic [`ADDR_W-1:0] O_REFRESH_ROW,
  output logic [`BANK_W-1:0] O_MR_SEL,
  output logic [`ADDR_W-1:0] O_MR_VALUE,
  output logic O_MR_LOAD,
  output ddr_cmd_pkg::col_req_t O_COL_REQ,
  output logic [LANES*8-1:0] O_RDATA
);
  import ddr_cmd_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic cmd_t decode(input cmd_bus_t c);
    if (c.cs_n) begin
      return CMD_DESEL;
    end
    case ({c.ras_n, c.cas_n, c.we_n})
      3'h7: return CMD_NOP;
      3'h0: return CMD_MRS;
      3'h1: return CMD_REF;
      3'h2: return CMD_PRE;
      3'h3: return CMD_ACT;
      3'h4: return CMD_WR;
      3'h5: return CMD_RD;
      default: return CMD_BAD;
    endcase
  endfunction

  function automatic logic is_quiet(input cmd_t c);
    return (c == CMD_DESEL) || (c == CMD_NOP);
  endfunction

  cmd_t cmd;
  logic cke_prev;
  logic next_cke_prev;
  assign cmd = decode(I_CMD);

  // ----------------------------------------
  // power state
  // ----------------------------------------
  power_state_t pstate;
  power_state_t next_pstate;
  logic dll_on;
  logic next_dll_on;
  logic all_idle;
  logic cmd_live;
  logic [NBANK-1:0] bank_open;
  logic [NBANK-1:0] next_bank_open;

  assign all_idle = (bank_open == '0);
  // commands only take effect with clock enable high on both edges
  assign cmd_live = cke_prev && I_CKE && (pstate == PS_IDLE || pstate == PS_ACTIVE);

  always_comb begin
    next_pstate = pstate;
    next_dll_on = dll_on;
    next_cke_prev = I_CKE;
    case (pstate)
      PS_IDLE, PS_ACTIVE: begin
        if (cke_prev && !I_CKE) begin
          if (all_idle && cmd == CMD_REF) begin
            next_pstate = PS_SELF_REF;
            next_dll_on = 1'b0;
          end else if (is_quiet(cmd)) begin
            next_pstate = all_idle ? PS_PRE_PD : PS_ACT_PD;
          end
        end else begin
          next_pstate = (all_idle && !(cmd_live && cmd == CMD_ACT)) ? PS_IDLE : PS_ACTIVE;
        end
      end
      PS_PRE_PD: begin
        if (!cke_prev && I_CKE) begin
          next_pstate = PS_IDLE;
        end
      end
      PS_ACT_PD: begin
        if (!cke_prev && I_CKE) begin
          next_pstate = PS_ACTIVE;
        end
      end
      PS_SELF_REF: begin
        // exit is taken from the level itself so the clock need not run before the rise
        if (I_CKE) begin
          next_pstate = PS_IDLE;
          next_dll_on = 1'b1;
        end
      end
      default: begin
        next_pstate = PS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pstate <= PS_IDLE;
      dll_on <= 1'b1;
      cke_prev <= 1'b0;
    end else begin
      pstate <= next_pstate;
      dll_on <= next_dll_on;
      cke_prev <= next_cke_prev;
    end
  end

  // ----------------------------------------
  // banks and refresh
  // ----------------------------------------
  logic [`ADDR_W-1:0] open_row [NBANK];
  logic [`ADDR_W-1:0] next_open_row [NBANK];
  logic [`ADDR_W-1:0] ref_row;
  logic [`ADDR_W-1:0] next_ref_row;
  logic ref_pulse;
  logic next_ref_pulse;
  col_req_t col_in;
  col_req_t col_out;
  logic [2:0] burst_cnt;
  logic [2:0] next_burst_cnt;
  col_req_t burst_req;
  col_req_t next_burst_req;

  always_comb begin
    col_in = '0;
    if (cmd_live && (cmd == CMD_RD || cmd == CMD_WR)) begin
      col_in.valid = 1'b1;
      col_in.write = (cmd == CMD_WR);
      col_in.auto_pre = I_CMD.addr[`AUTO_PRE_BIT];
      col_in.bank = I_CMD.bank;
      col_in.col = I_CMD.addr[`COL_W-1:0];
    end
  end

  ddr_col_delay #(
    .DEPTH(7)
  ) u_delay (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_latency(I_ADDITIVE_LATENCY),
    .i_req(col_in),
    .o_req(col_out)
  );

  always_comb begin
    next_bank_open = bank_open;
    next_open_row = open_row;
    next_ref_row = ref_row;
    next_ref_pulse = 1'b0;
    next_burst_cnt = burst_cnt;
    next_burst_req = burst_req;
    // auto-precharge closes the row when its burst ends; other banks stay usable
    if (burst_cnt != 3'h0) begin
      next_burst_cnt = burst_cnt - 3'h1;
      if (burst_cnt == 3'h1 && burst_req.auto_pre) begin
        next_bank_open[burst_req.bank] = 1'b0;
      end
    end
    if (col_out.valid) begin
      next_burst_req = col_out;
      next_burst_cnt = 3'(`BURST_LEN / 2);
    end
    if (cmd_live) begin
      case (cmd)
        CMD_ACT: begin
          next_bank_open[I_CMD.bank] = 1'b1;
          next_open_row[I_CMD.bank] = I_CMD.addr;
        end
        CMD_PRE: begin
          // idle or already closing banks simply close again
          if (I_CMD.addr[`AUTO_PRE_BIT]) begin
            next_bank_open = '0;
          end else begin
            next_bank_open[I_CMD.bank] = 1'b0;
          end
        end
        CMD_REF: begin
          // address pins ignored, row comes from the internal counter
          next_ref_pulse = 1'b1;
          next_ref_row = ref_row + 14'h0001;
        end
        default: begin
        end
      endcase
    end
    // power-down states never refresh
    if (pstate != PS_IDLE && pstate != PS_ACTIVE) begin
      next_ref_pulse = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      bank_open <= '0;
      ref_row <= `ROW_RESET;
      ref_pulse <= 1'b0;
      burst_cnt <= 3'h0;
      burst_req <= '0;
      for (int i = 0; i < NBANK; i++) begin
        open_row[i] <= `ROW_RESET;
      end
    end else begin
      bank_open <= next_bank_open;
      ref_row <= next_ref_row;
      ref_pulse <= next_ref_pulse;
      burst_cnt <= next_burst_cnt;
      burst_req <= next_burst_req;
      open_row <= next_open_row;
    end
  end

  // ----------------------------------------
  // mode registers and termination
  // ----------------------------------------
  logic [`BANK_W-1:0] mr_sel;
  logic [`BANK_W-1:0] next_mr_sel;
  logic [`ADDR_W-1:0] mr_value;
  logic [`ADDR_W-1:0] next_mr_value;
  logic mr_load;
  logic next_mr_load;
  logic term_en;
  logic next_term_en;
  logic term_on;
  logic next_term_on;

  always_comb begin
    next_mr_sel = mr_sel;
    next_mr_value = mr_value;
    next_mr_load = 1'b0;
    next_term_en = term_en;
    if (cmd_live && cmd == CMD_MRS) begin
      next_mr_sel = I_CMD.bank;
      next_mr_value = I_CMD.addr;
      next_mr_load = 1'b1;
      if (I_CMD.bank == `EMR1_SEL) begin
        next_term_en = I_CMD.addr[`MR_A2_BIT] | I_CMD.addr[`MR_A6_BIT];
      end
    end
    // termination is held off from the second self-refresh cycle on, whatever the pin shows
    next_term_on = term_en && I_TERM_CTRL && (pstate != PS_SELF_REF);
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mr_sel <= 3'h0;
      mr_value <= 14'h0000;
      mr_load <= 1'b0;
      term_en <= 1'b0;
      term_on <= 1'b0;
    end else begin
      mr_sel <= next_mr_sel;
      mr_value <= next_mr_value;
      mr_load <= next_mr_load;
      term_en <= next_term_en;
      term_on <= next_term_on;
    end
  end

  // ----------------------------------------
  // write data store
  // ----------------------------------------
  ddr_byte_mem #(
    .AW(MEM_AW),
    .LANES(LANES)
  ) u_mem (
    .I_CLK(I_CLK),
    .i_we(col_out.valid && col_out.write),
    .i_waddr(col_out.col[MEM_AW-1:0]),
    .i_wdata(I_WDATA),
    .i_mask(I_BYTE_WRITE_MASK),
    .i_raddr(col_out.col[MEM_AW-1:0]),
    .o_rdata(O_RDATA)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign O_POWER_STATE = pstate;
  assign O_BANK_OPEN = bank_open;
  assign O_DLL_ON = dll_on;
  assign O_TERM_ON = term_on;
  assign O_REFRESH_PULSE = ref_pulse;
  assign O_REFRESH_ROW = ref_row;
  assign O_MR_SEL = mr_sel;
  assign O_MR_VALUE = mr_value;
  assign O_MR_LOAD = mr_load;
  assign O_COL_REQ = col_out;
endmodule

// file: dv/ddr_cmd_power_monitor.sv
// assertion checker for the command and power-state block
module ddr_cmd_power_monitor import ddr_cmd_pkg::*; #(
  parameter int NBANK = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // watched inputs
  input wire logic I_CKE,
  input wire ddr_cmd_pkg::cmd_bus_t I_CMD,
  input wire logic [2:0] I_ADDITIVE_LATENCY,
  // watched outputs
  input wire ddr_cmd_pkg::power_state_t O_POWER_STATE,
  input wire logic [NBANK-1:0] O_BANK_OPEN,
  input wire logic O_DLL_ON,
  input wire logic O_TERM_ON,
  input wire logic O_REFRESH_PULSE,
  input wire logic [13:0] O_REFRESH_ROW,
  input wire logic [2:0] O_MR_SEL,
  input wire logic [13:0] O_MR_VALUE,
  input wire logic O_MR_LOAD,
  input wire ddr_cmd_pkg::col_req_t O_COL_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // helpers
  // ------------------------------
  logic cke_prev;
  logic [3:0] strb;
  logic live;
  logic idle_cmd;
  // resets to 0 like the block, so no command counts on the first edge after reset
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= I_CKE;
    end
  end
  assign strb = {I_CMD.cs_n, I_CMD.ras_n, I_CMD.cas_n, I_CMD.we_n};
  assign idle_cmd = I_CMD.cs_n || strb == 4'h7;
  assign live = cke_prev && I_CKE && !I_CMD.cs_n && (O_POWER_STATE == PS_IDLE || O_POWER_STATE == PS_ACTIVE);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_col_taken;
    live && (strb == 4'h4 || strb == 4'h5) && I_ADDITIVE_LATENCY == 3'h2;
  endsequence
  sequence s_col_out;
    ##2 O_COL_REQ.valid && O_COL_REQ.bank == $past(I_CMD.bank, 2);
  endsequence
  // ------------------------------
  // properties
  // ------------------------------
  a_act_opens_bank: assert property (live && strb == 4'h3 |=> O_BANK_OPEN[$past(I_CMD.bank)])
    else $error("activate left its bank closed");
  a_pre_closes_bank: assert property (live && strb == 4'h2 && !I_CMD.addr[10] |=> !O_BANK_OPEN[$past(I_CMD.bank)])
    else $error("precharge left its bank open");
  a_pre_all_banks: assert property (live && strb == 4'h2 && I_CMD.addr[10] |=> O_BANK_OPEN == '0)
    else $error("precharge all left a bank open");
  a_mode_load: assert property (live && strb == 4'h0 |=> O_MR_LOAD && O_MR_SEL == $past(I_CMD.bank)
    && O_MR_VALUE == $past(I_CMD.addr)) else $error("mode load target or value wrong");
  a_refresh_count: assert property (live && strb == 4'h1 |=> O_REFRESH_PULSE
    && O_REFRESH_ROW == $past(O_REFRESH_ROW) + 14'h0001) else $error("refresh row did not advance");
  a_quiet_nop: assert property (idle_cmd |=> !O_MR_LOAD && !O_REFRESH_PULSE)
    else $error("deselect or nop caused an action");
  a_pre_pd_entry: assert property (cke_prev && !I_CKE && O_BANK_OPEN == '0 && idle_cmd
    && (O_POWER_STATE == PS_IDLE || O_POWER_STATE == PS_ACTIVE)
    |=> O_POWER_STATE == PS_PRE_PD) else $error("no precharge power-down entry");
  a_act_pd_entry: assert property (cke_prev && !I_CKE && O_BANK_OPEN != '0 && idle_cmd
    && O_POWER_STATE == PS_ACTIVE
    |=> O_POWER_STATE == PS_ACT_PD) else $error("no active power-down entry");
  a_self_entry: assert property (cke_prev && !I_CKE && O_POWER_STATE == PS_IDLE && strb == 4'h1
    |=> O_POWER_STATE == PS_SELF_REF && !O_DLL_ON) else $error("self-refresh entry wrong");
  a_self_exit: assert property (O_POWER_STATE == PS_SELF_REF && I_CKE |=> O_POWER_STATE == PS_IDLE && O_DLL_ON)
    else $error("self-refresh exit wrong");
  a_pd_no_refresh: assert property (O_POWER_STATE != PS_IDLE && O_POWER_STATE != PS_ACTIVE |=> !O_REFRESH_PULSE)
    else $error("refresh during power-down");
  a_self_term_off: assert property (O_POWER_STATE == PS_SELF_REF ##1 O_POWER_STATE == PS_SELF_REF |-> !O_TERM_ON)
    else $error("termination on in self-refresh");
  a_col_latency: assert property (s_col_taken |-> s_col_out)
    else $error("column request not delayed by additive latency");
endmodule
bind ddr_cmd_power ddr_cmd_power_monitor #(.NBANK(NBANK)) u_monitor (.I_CLK, .I_RST, .I_CKE, .I_CMD,
  .I_ADDITIVE_LATENCY, .O_POWER_STATE, .O_BANK_OPEN, .O_DLL_ON, .O_TERM_ON, .O_REFRESH_PULSE,
  .O_REFRESH_ROW, .O_MR_SEL, .O_MR_VALUE, .O_MR_LOAD, .O_COL_REQ);

// file: dv/ddr_ctrl_model.sv
// controller-side model turning a command code into pin levels
module ddr_ctrl_model import ddr_cmd_pkg::*; (
  input wire logic i_clk,
  input wire ddr_cmd_pkg::cmd_t i_op,
  input wire logic [2:0] i_bank,
  input wire logic [13:0] i_addr,
  input wire logic i_cke,
  output ddr_cmd_pkg::cmd_bus_t o_cmd,
  output logic o_cke
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  logic [3:0] strb;
  // plain always: the start value comes from the declaration, which always_ff would not allow
  always @(posedge i_clk) begin
    flip <= ~flip;
  end
  always_comb begin
    case (i_op)
      CMD_MRS: strb = 4'h0;
      CMD_REF: strb = 4'h1;
      CMD_PRE: strb = 4'h2;
      CMD_ACT: strb = 4'h3;
      CMD_WR: strb = 4'h4;
      CMD_RD: strb = 4'h5;
      CMD_DESEL: strb = {1'b1, {3{flip}}};
      default: strb = 4'h7;
    endcase
  end
  // don't-care address pins of refresh and deselect toggle so a block that reads them cannot pass by luck
  assign o_cmd = {strb, i_bank, (i_op == CMD_REF || i_op == CMD_DESEL) ? {14{flip}} : i_addr};
  assign o_cke = i_cke;
endmodule

// file: dv/tb_ddr_cmd_power.sv
// self-checking bench for the command and power-state block
module tb_ddr_cmd_power;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_cmd_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_TERM_CTRL = 1'b0;
  logic [15:0] I_WDATA = 16'h0000;
  logic [1:0] I_BYTE_WRITE_MASK = 2'h0;
  logic [2:0] I_ADDITIVE_LATENCY = 3'h0;
  cmd_t op = CMD_NOP;
  logic [2:0] bank = 3'h0;
  logic [13:0] addr = 14'h0000;
  logic cke = 1'b1;
  logic I_CKE;
  cmd_bus_t I_CMD;
  power_state_t O_POWER_STATE;
  logic [7:0] O_BANK_OPEN;
  logic O_DLL_ON, O_TERM_ON, O_REFRESH_PULSE, O_MR_LOAD;
  logic [13:0] O_REFRESH_ROW, O_MR_VALUE;
  logic [2:0] O_MR_SEL;
  col_req_t O_COL_REQ;
  logic [15:0] O_RDATA;
  int bad_count = 0;
  int compares = 0;
  always #2.5 I_CLK = ~I_CLK;
  ddr_ctrl_model u_ctrl (.i_clk(I_CLK), .i_op(op), .i_bank(bank), .i_addr(addr), .i_cke(cke), .o_cmd(I_CMD),
    .o_cke(I_CKE));
  ddr_cmd_power DUT (.I_CLK, .I_RST, .I_CKE, .I_CMD, .I_TERM_CTRL, .I_WDATA, .I_BYTE_WRITE_MASK,
    .I_ADDITIVE_LATENCY, .O_POWER_STATE, .O_BANK_OPEN, .O_DLL_ON, .O_TERM_ON, .O_REFRESH_PULSE,
    .O_REFRESH_ROW, .O_MR_SEL, .O_MR_VALUE, .O_MR_LOAD, .O_COL_REQ, .O_RDATA);
  // ------------------------------
  // checks and drivers
  // ------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input power_state_t got, input power_state_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input cmd_t o, input logic [2:0] b, input logic [13:0] a, input logic k);
    @(posedge I_CLK);
    op <= o;
    bank <= b;
    addr <= a;
    cke <= k;
  endtask
  task automatic nops(input int n, input logic k);
    repeat (n) issue(CMD_NOP, 3'h0, 14'h0000, k);
  endtask
  // waits out the delayed column request, then one edge for the store or read
  task automatic col_wait(input logic rd, input logic [15:0] exp);
    int i;
    i = 0;
    #1;
    while (O_COL_REQ.valid !== 1'b1 && i < 10) begin
      nops(1, 1'b1);
      #1;
      i++;
    end
    if (i == 10) begin
      bad_count++;
      give_verdict();
    end
    chk_val(16'(i), 16'h0002);
    nops(1, 1'b1);
    #1;
    if (rd) chk_val(O_RDATA, exp);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_banks();
    chk_state(O_POWER_STATE, PS_IDLE);
    chk_val(16'(O_DLL_ON), 16'h0001);
    issue(CMD_ACT, 3'h1, 14'h0123, 1'b1);
    issue(CMD_DESEL, 3'h2, 14'h0000, 1'b1);
    issue(CMD_DESEL, 3'h2, 14'h0000, 1'b1);
    nops(1, 1'b1);
    #1;
    chk_val(16'(O_BANK_OPEN), 16'h0002);
    issue(CMD_PRE, 3'h1, 14'h0000, 1'b1);
    issue(CMD_PRE, 3'h1, 14'h0000, 1'b1);
    issue(CMD_ACT, 3'h3, 14'h0001, 1'b1);
    issue(CMD_ACT, 3'h5, 14'h0002, 1'b1);
    nops(1, 1'b1);
    #1;
    chk_val(16'(O_BANK_OPEN), 16'h0028);
    issue(CMD_PRE, 3'h0, 14'h0400, 1'b1);
    nops(3, 1'b1);
    #1;
    chk_val(16'(O_BANK_OPEN), 16'h0000);
  endtask
  task automatic t_mode_refresh();
    issue(CMD_MRS, 3'h1, 14'h0044, 1'b1);
    I_TERM_CTRL <= 1'b1;
    nops(3, 1'b1);
    #1;
    chk_val(16'(O_MR_SEL), 16'h0001);
    chk_val(16'(O_MR_VALUE), 16'h0044);
    chk_val(16'(O_TERM_ON), 16'h0001);
    issue(CMD_REF, 3'h0, 14'h0000, 1'b1);
    I_TERM_CTRL <= 1'b0;
    issue(CMD_REF, 3'h0, 14'h0000, 1'b1);
    nops(1, 1'b1);
    #1;
    chk_val(16'(O_TERM_ON), 16'h0000);
    chk_val(16'(O_REFRESH_ROW), 16'h0002);
  endtask
  task automatic t_power();
    nops(3, 1'b0);
    #1;
    chk_state(O_POWER_STATE, PS_PRE_PD);
    issue(CMD_REF, 3'h0, 14'h0000, 1'b0);
    nops(3, 1'b1);
    #1;
    chk_state(O_POWER_STATE, PS_IDLE);
    chk_val(16'(O_REFRESH_ROW), 16'h0002);
    issue(CMD_ACT, 3'h0, 14'h0003, 1'b1);
    nops(3, 1'b0);
    #1;
    chk_state(O_POWER_STATE, PS_ACT_PD);
    nops(3, 1'b1);
    #1;
    chk_state(O_POWER_STATE, PS_ACTIVE);
    issue(CMD_PRE, 3'h0, 14'h0000, 1'b1);
    nops(4, 1'b1);
  endtask
  task automatic t_self();
    issue(CMD_REF, 3'h0, 14'h0000, 1'b0);
    I_TERM_CTRL <= 1'b1;
    nops(3, 1'b0);
    #1;
    chk_state(O_POWER_STATE, PS_SELF_REF);
    chk_val(16'(O_DLL_ON), 16'h0000);
    chk_val(16'(O_TERM_ON), 16'h0000);
    nops(2, 1'b1);
    #1;
    chk_state(O_POWER_STATE, PS_IDLE);
    chk_val(16'(O_DLL_ON), 16'h0001);
    nops(200, 1'b1);
  endtask
  task automatic t_column();
    issue(CMD_ACT, 3'h1, 14'h0010, 1'b1);
    I_ADDITIVE_LATENCY <= 3'h2;
    issue(CMD_ACT, 3'h2, 14'h0020, 1'b1);
    issue(CMD_WR, 3'h1, 14'h0006, 1'b1);
    I_WDATA <= 16'hFFFF;
    col_wait(1'b0, 16'h0000);
    issue(CMD_WR, 3'h1, 14'h0006, 1'b1);
    I_WDATA <= 16'h1234;
    I_BYTE_WRITE_MASK <= 2'h2;
    col_wait(1'b0, 16'h0000);
    issue(CMD_RD, 3'h1, 14'h0406, 1'b1);
    col_wait(1'b1, 16'hFF34);
    issue(CMD_RD, 3'h2, 14'h0006, 1'b1);
    col_wait(1'b1, 16'hFF34);
    chk_val(16'(O_BANK_OPEN), 16'h0004);
    issue(CMD_WR, 3'h2, 14'h0406, 1'b1);
    I_BYTE_WRITE_MASK <= 2'h3;
    col_wait(1'b0, 16'h0000);
    nops(3, 1'b1);
    #1;
    chk_val(16'(O_BANK_OPEN), 16'h0000);
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (10) @(posedge I_CLK);
    I_RST <= 1'b0;
    nops(3, 1'b1);
    #1;
    t_banks();
    t_mode_refresh();
    t_power();
    t_self();
    t_column();
    give_verdict();
  end
endmodule
